// file: rtl/wbm_defs.vh
// Constants of the watchdog and bus mode register bank
`ifndef WBM_DEFS_VH
`define WBM_DEFS_VH
// Register addresses (7-bit)
`define WBM_ADDR_WDOG 7'h03
`define WBM_ADDR_BUS1 7'h04
`define WBM_ADDR_BUS2 7'h05
// Command byte layout
`define WBM_CMD_WRITE_BIT 7
// Watchdog control fields
`define WBM_WD_PARITY 7
`define WBM_WD_STOP_DIS 6
`define WBM_WD_WINDOW 5
`define WBM_WD_BUS_WAKE 4
`define WBM_WD_MAX3 3
`define WBM_WD_PER_HI 2
// Bus control fields
`define WBM_B1_FLASH 7
`define WBM_B1_LOW_SLOPE 6
`define WBM_B1_TX_TO 5
`define WBM_B1_LINA_HI 4
`define WBM_B1_CAN_HI 1
`define WBM_B1_WMASK 8'hfb
`define WBM_B2_WMASK 8'hdb
// Watchdog bits hardware may update
`define WBM_WD_HWMASK 8'h57
// Reset values
`define WBM_WD_RST 8'h14
`define WBM_B1_RST 8'h20
`define WBM_B2_RST 8'h00
// Restart: keep mask, then OR value
`define WBM_WD_RS_KEEP 8'h18
`define WBM_WD_RS_SET 8'h04
`define WBM_B1_RS_KEEP 8'hfb
`define WBM_B2_RS_KEEP 8'hdb
// Transceiver mode codes
`define WBM_MODE_WAKE 2'h1
`define WBM_MODE_NORMAL 2'h3
// Device operating modes
`define WBM_DEV_NORMAL 2'h0
`define WBM_DEV_SLEEP 2'h1
`define WBM_DEV_STOP 2'h2
// Watchdog reset limit
`define WBM_MAX_WD_RESETS 2'h3
// Period table in ms
`define WBM_PER_0 10'd10
`define WBM_PER_1 10'd20
`define WBM_PER_2 10'd50
`define WBM_PER_3 10'd100
`define WBM_PER_4 10'd200
`define WBM_PER_5 10'd500
`define WBM_PER_6 10'd1000
// Frame and header lengths in bits
`define WBM_FRAME_BITS 5'd16
`define WBM_HDR_BITS 5'd8
`endif

// file: rtl/wbm_serial_slave.v
// Serial 16-bit command link slave, pins sampled by the system clock
`timescale 1ns/1ps
`include "wbm_defs.vh"
module wbm_serial_slave
(
  // System
  input wire clk,
  input wire resetn,
  // Link pins
  input wire selN,
  input wire sclk,
  input wire mosi,
  output reg misoOut,
  output reg misoOe,
  // Block side
  input wire [7:0] statusByte,
  input wire [7:0] rdByte,
  output reg hdrValid,
  output reg [7:0] hdrByte,
  output reg frameValid,
  output reg frameErr,
  output reg [15:0] frameWord
);
  // Two-stage synchronisers
  reg [1:0] selSync_q;
  reg [1:0] sclkSync_q;
  reg [1:0] mosiSync_q;
  // Delayed copies for edge detection
  reg selOld_q;
  reg sclkOld_q;
  // Shift registers and counters
  reg [15:0] rxShift_q;
  reg [7:0] txShift_q;
  reg [4:0] bitCnt_q;
  reg loadPend_q;
  wire selLow = ~selSync_q[1];
  wire selFall = selOld_q & ~selSync_q[1];
  wire selRise = ~selOld_q & selSync_q[1];
  wire sclkRise = ~sclkOld_q & sclkSync_q[1];
  wire sclkFall = sclkOld_q & ~sclkSync_q[1];

  // Synchronise and remember pins
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      selSync_q <= 2'h3;
      sclkSync_q <= 2'h0;
      mosiSync_q <= 2'h0;
      selOld_q <= 1'b1;
      sclkOld_q <= 1'b0;
    end
    else
    begin
      selSync_q <= {selSync_q[0], selN};
      sclkSync_q <= {sclkSync_q[0], sclk};
      mosiSync_q <= {mosiSync_q[0], mosi};
      selOld_q <= selSync_q[1];
      sclkOld_q <= sclkSync_q[1];
    end
  end

  // Receive on rising, send on falling, LSB first
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      rxShift_q <= 16'h0000;
      txShift_q <= 8'h00;
      bitCnt_q <= 5'd0;
      loadPend_q <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      hdrValid <= 1'b0;
      hdrByte <= 8'h00;
      frameValid <= 1'b0;
      frameErr <= 1'b0;
      frameWord <= 16'h0000;
    end
    else
    begin
      hdrValid <= 1'b0;
      frameValid <= 1'b0;
      frameErr <= 1'b0;
      misoOe <= selLow;
      loadPend_q <= hdrValid;
      if (selFall)
      begin
        // Status byte goes out first
        bitCnt_q <= 5'd0;
        misoOut <= statusByte[0];
        txShift_q <= {1'b0, statusByte[7:1]};
      end
      else if (selRise)
      begin
        // Only frames of at least 16 bits are acted on, bits past the 16th dropped
        if (bitCnt_q == `WBM_FRAME_BITS)
        begin
          frameValid <= 1'b1;
          frameWord <= rxShift_q;
        end
        else
          frameErr <= 1'b1;
      end
      else if (selLow)
      begin
        if (sclkRise && bitCnt_q != `WBM_FRAME_BITS)
        begin
          rxShift_q <= {mosiSync_q[1], rxShift_q[15:1]};
          bitCnt_q <= bitCnt_q + 5'd1;
          if (bitCnt_q == `WBM_HDR_BITS - 5'd1)
          begin
            hdrValid <= 1'b1;
            hdrByte <= {mosiSync_q[1], rxShift_q[15:9]};
          end
        end
        // Read data arrives a cycle after the header, well before the next fall
        if (loadPend_q)
          txShift_q <= rdByte;
        else if (sclkFall)
        begin
          misoOut <= txShift_q[0];
          txShift_q <= {1'b0, txShift_q[7:1]};
        end
      end
    end
  end
endmodule // wbm_serial_slave

// file: rtl/wbm_regs.v
// Watchdog and bus mode control register bank behind the serial link
`timescale 1ns/1ps
`include "wbm_defs.vh"
module wbm_regs
(
  // System
  input wire clk,
  input wire resetn,
  // Reset kinds from the mode controller
  input wire softReset,
  input wire restart,
  // Serial link pins
  input wire selN,
  input wire sclk,
  input wire mosi,
  output wire misoOut,
  output wire misoOe,
  // Device state
  input wire [1:0] devMode,
  input wire busWake,
  input wire wdogTimeout,
  input wire wdogEarly,
  input wire wdogServiceOk,
  input wire spiFailClr,
  // Hardware updates of updatable fields
  input wire hwWdogUpd,
  input wire [7:0] hwWdogVal,
  input wire hwBusUpd,
  input wire [1:0] hwCanMode,
  input wire [1:0] hwLinAMode,
  input wire [1:0] hwLinBMode,
  input wire [1:0] hwLinCMode,
  input wire [1:0] hwLinDMode,
  // Watchdog configuration
  output reg wdogStopDisable,
  output reg wdogWindowSelect,
  output reg wdogRunning,
  output reg wdogLongWinStart,
  output reg wdogResetReq,
  output reg wdogResetBlocked,
  output reg [9:0] wdogPeriodMs,
  // LIN options
  output reg linFlash,
  output reg linLowSlope,
  output reg linTxTimeoutEn,
  // Effective transceiver modes
  output reg [1:0] canModeEff,
  output reg [1:0] linAModeEff,
  output reg [1:0] linBModeEff,
  output reg [1:0] linCModeEff,
  output reg [1:0] linDModeEff,
  // Serial failure flag
  output reg spiFail
);
  // Stored registers
  reg [7:0] wdogCtrl_q;
  reg [7:0] busCtrl1_q;
  reg [7:0] busCtrl2_q;
  // Consecutive watchdog-caused resets
  reg [1:0] wdResetCnt_q;
  // Read data latched at header time
  reg [7:0] rdByte_q;
  // Link side wires
  wire hdrValid;
  wire [7:0] hdrByte;
  wire frameValid;
  wire frameErr;
  wire [15:0] frameWord;
  wire [6:0] cmdAddr = frameWord[6:0];
  wire [7:0] cmdData = frameWord[15:8];
  wire cmdWrite = frameValid & frameWord[`WBM_CMD_WRITE_BIT];
  wire parityOk = ~^cmdData;
  wire wrWdog = cmdWrite & (cmdAddr == `WBM_ADDR_WDOG);
  wire wrBus1 = cmdWrite & (cmdAddr == `WBM_ADDR_BUS1);
  wire wrBus2 = cmdWrite & (cmdAddr == `WBM_ADDR_BUS2);
  // Low power covers stop and sleep only; any other code runs as normal
  wire lowPower = (devMode == `WBM_DEV_STOP) | (devMode == `WBM_DEV_SLEEP);
  wire inStop = devMode == `WBM_DEV_STOP;
  // early service fails only in window mode
  wire wdFailNow = wdogTimeout | (wdogEarly & wdogCtrl_q[`WBM_WD_WINDOW]);
  // Read mux output
  reg [7:0] rdMux;
  // Status byte presented at frame start
  wire [7:0] statusByte = {7'h00, spiFail};

  // Link front end
  wbm_serial_slave u_link
  (
    .clk(clk),
    .resetn(resetn),
    .selN(selN),
    .sclk(sclk),
    .mosi(mosi),
    .misoOut(misoOut),
    .misoOe(misoOe),
    .statusByte(statusByte),
    .rdByte(rdByte_q),
    .hdrValid(hdrValid),
    .hdrByte(hdrByte),
    .frameValid(frameValid),
    .frameErr(frameErr),
    .frameWord(frameWord)
  );

  // Read mux on header address
  always @*
  begin
    case (hdrByte[6:0])
      `WBM_ADDR_WDOG: rdMux = {1'b0, wdogCtrl_q[6:0]};
      `WBM_ADDR_BUS1: rdMux = busCtrl1_q & `WBM_B1_WMASK;
      `WBM_ADDR_BUS2: rdMux = busCtrl2_q & `WBM_B2_WMASK;
      // Unmapped addresses read zero
      default: rdMux = 8'h00;
    endcase
  end

  // Latch read byte when header completes
  always @(posedge clk)
  begin
    if (!resetn)
      rdByte_q <= 8'h00;
    // Taken at header time, so a reply shows the state before this frame
    else if (hdrValid)
      rdByte_q <= rdMux;
  end

  // Watchdog control register
  always @(posedge clk)
  begin
    if (!resetn || softReset)
      wdogCtrl_q <= `WBM_WD_RST;
    // restart keeps bits 4 and 3
    else if (restart)
      wdogCtrl_q <= (wdogCtrl_q & `WBM_WD_RS_KEEP) | `WBM_WD_RS_SET;
    else if (hwWdogUpd)
      wdogCtrl_q <= (wdogCtrl_q & ~`WBM_WD_HWMASK) | (hwWdogVal & `WBM_WD_HWMASK);
    else if (wrWdog && parityOk)
      wdogCtrl_q <= {1'b0, cmdData[6:0]};
  end

  // First bus control register
  always @(posedge clk)
  begin
    if (!resetn || softReset)
      busCtrl1_q <= `WBM_B1_RST;
    else if (restart)
      busCtrl1_q <= busCtrl1_q & `WBM_B1_RS_KEEP;
    else if (hwBusUpd)
      busCtrl1_q <= {busCtrl1_q[7:5], hwLinAMode, 1'b0, hwCanMode};
    else if (wrBus1)
      busCtrl1_q <= cmdData & `WBM_B1_WMASK;
  end

  // Second bus control register
  always @(posedge clk)
  begin
    if (!resetn || softReset)
      busCtrl2_q <= `WBM_B2_RST;
    else if (restart)
      busCtrl2_q <= busCtrl2_q & `WBM_B2_RS_KEEP;
    else if (hwBusUpd)
      busCtrl2_q <= {hwLinDMode, 1'b0, hwLinCMode, 1'b0, hwLinBMode};
    else if (wrBus2)
      busCtrl2_q <= cmdData & `WBM_B2_WMASK;
  end

  // Serial failure flag, set wins over clear
  always @(posedge clk)
  begin
    if (!resetn || softReset)
      spiFail <= 1'b0;
    else if ((wrWdog && !parityOk) || frameErr)
      spiFail <= 1'b1;
    // Clear loses to a set in the same cycle
    else if (spiFailClr)
      spiFail <= 1'b0;
  end

  // Watchdog reset limiting
  always @(posedge clk)
  begin
    if (!resetn || softReset)
    begin
      wdResetCnt_q <= 2'h0;
      wdogResetReq <= 1'b0;
      wdogResetBlocked <= 1'b0;
    end
    else
    begin
      wdogResetReq <= 1'b0;
      if (wdFailNow)
      begin
        if (!wdogCtrl_q[`WBM_WD_MAX3] || wdResetCnt_q != `WBM_MAX_WD_RESETS)
        begin
          wdogResetReq <= 1'b1;
          // Saturate so a long failure run never wraps to zero
          if (wdResetCnt_q != `WBM_MAX_WD_RESETS)
            wdResetCnt_q <= wdResetCnt_q + 2'h1;
        end
      end
      // A good service breaks the run
      else if (wdogServiceOk)
        wdResetCnt_q <= 2'h0;
      // Level output, so the supervisor can see why resets stopped
      wdogResetBlocked <= wdogCtrl_q[`WBM_WD_MAX3] &
        (wdResetCnt_q == `WBM_MAX_WD_RESETS);
    end
  end

  // Watchdog configuration outputs
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      wdogStopDisable <= 1'b0;
      wdogWindowSelect <= 1'b0;
      wdogRunning <= 1'b1;
      wdogLongWinStart <= 1'b0;
      wdogPeriodMs <= `WBM_PER_0;
    end
    else
    begin
      wdogStopDisable <= wdogCtrl_q[`WBM_WD_STOP_DIS];
      wdogWindowSelect <= wdogCtrl_q[`WBM_WD_WINDOW];
      wdogRunning <= ~(inStop & wdogCtrl_q[`WBM_WD_STOP_DIS]);
      // long open window after bus wake
      wdogLongWinStart <= busWake & inStop & wdogCtrl_q[`WBM_WD_BUS_WAKE];
      case (wdogCtrl_q[`WBM_WD_PER_HI:0])
        3'h0: wdogPeriodMs <= `WBM_PER_0;
        3'h1: wdogPeriodMs <= `WBM_PER_1;
        3'h2: wdogPeriodMs <= `WBM_PER_2;
        3'h3: wdogPeriodMs <= `WBM_PER_3;
        3'h4: wdogPeriodMs <= `WBM_PER_4;
        3'h5: wdogPeriodMs <= `WBM_PER_5;
        3'h6: wdogPeriodMs <= `WBM_PER_6;
        // Reserved code shows zero
        default: wdogPeriodMs <= 10'd0;
      endcase
    end
  end

  // Effective mode: stored normal runs as wake-capable in low power
  function [1:0] effMode;
    input [1:0] stored;
    input lp;
    begin
      effMode = (lp && stored == `WBM_MODE_NORMAL) ? `WBM_MODE_WAKE : stored;
    end
  endfunction

  // LIN options and transceiver modes
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      linFlash <= 1'b0;
      linLowSlope <= 1'b0;
      linTxTimeoutEn <= 1'b1;
      canModeEff <= 2'h0;
      linAModeEff <= 2'h0;
      linBModeEff <= 2'h0;
      linCModeEff <= 2'h0;
      linDModeEff <= 2'h0;
    end
    else
    begin
      linFlash <= busCtrl1_q[`WBM_B1_FLASH];
      linLowSlope <= busCtrl1_q[`WBM_B1_LOW_SLOPE];
      linTxTimeoutEn <= busCtrl1_q[`WBM_B1_TX_TO];
      canModeEff <= effMode(busCtrl1_q[`WBM_B1_CAN_HI -: 2], lowPower);
      linAModeEff <= effMode(busCtrl1_q[`WBM_B1_LINA_HI -: 2], lowPower);
      linBModeEff <= effMode(busCtrl2_q[1:0], lowPower);
      linCModeEff <= effMode(busCtrl2_q[4:3], lowPower);
      linDModeEff <= effMode(busCtrl2_q[7:6], lowPower);
    end
  end
endmodule // wbm_regs

// file: sim/wbm_regs_properties.sv
// Concurrent checks on the watchdog and bus mode register bank ports
`timescale 1ns/1ps
module wbm_regs_properties
(
  // System
  input wire clk,
  input wire resetn,
  // Inputs watched
  input wire softReset,
  input wire [1:0] devMode,
  input wire busWake,
  input wire wdogTimeout,
  input wire wdogEarly,
  input wire spiFailClr,
  // Outputs watched
  input wire wdogStopDisable,
  input wire wdogWindowSelect,
  input wire wdogRunning,
  input wire wdogLongWinStart,
  input wire wdogResetReq,
  input wire [9:0] wdogPeriodMs,
  input wire [1:0] canModeEff,
  input wire [1:0] linAModeEff,
  input wire [1:0] linBModeEff,
  input wire [1:0] linCModeEff,
  input wire [1:0] linDModeEff,
  input wire spiFail
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_period_table: assert property (
    wdogPeriodMs inside {10'd10, 10'd20, 10'd50, 10'd100, 10'd200, 10'd500, 10'd1000, 10'd0})
    else $error("period output outside the table");
  chk_stop_off: assert property (
    $past(devMode) == 2'h2 && wdogStopDisable |-> !wdogRunning)
    else $error("watchdog runs in stop although disabled there");
  chk_run_awake: assert property (
    $past(devMode) != 2'h2 |-> wdogRunning)
    else $error("watchdog stopped outside stop mode");
  chk_long_window: assert property (
    wdogLongWinStart |-> $past(busWake) && $past(devMode) == 2'h2)
    else $error("long window start without bus wake in stop");
  chk_reset_cause: assert property (
    wdogResetReq |-> $past(wdogTimeout) || ($past(wdogEarly) && wdogWindowSelect))
    else $error("watchdog reset without a failure");
  chk_can_lowpower: assert property (
    ($past(devMode) == 2'h1 || $past(devMode) == 2'h2) |-> canModeEff != 2'h3)
    else $error("CAN normal while in low power");
  chk_lin_lowpower: assert property (
    ($past(devMode) == 2'h1 || $past(devMode) == 2'h2) |-> linAModeEff != 2'h3
      && linBModeEff != 2'h3
      && linCModeEff != 2'h3 && linDModeEff != 2'h3)
    else $error("LIN normal while in low power");
  chk_fail_sticky: assert property (
    $fell(spiFail) |-> $past(spiFailClr) || $past(spiFailClr, 2) || $past(softReset)
      || $past(softReset, 2))
    else $error("serial failure flag dropped by itself");
endmodule // wbm_regs_properties

bind wbm_regs wbm_regs_properties u_props (.clk(clk), .resetn(resetn), .softReset(softReset),
  .devMode(devMode), .busWake(busWake), .wdogTimeout(wdogTimeout), .wdogEarly(wdogEarly),
  .spiFailClr(spiFailClr), .wdogStopDisable(wdogStopDisable),
  .wdogWindowSelect(wdogWindowSelect), .wdogRunning(wdogRunning),
  .wdogLongWinStart(wdogLongWinStart), .wdogResetReq(wdogResetReq),
  .wdogPeriodMs(wdogPeriodMs), .canModeEff(canModeEff), .linAModeEff(linAModeEff),
  .linBModeEff(linBModeEff), .linCModeEff(linCModeEff), .linDModeEff(linDModeEff),
  .spiFail(spiFail));

// file: sim/wbm_host_model.sv
// Host side link master sending framed 16-bit commands
`timescale 1ns/1ps
module wbm_host_model
(
  // System
  input wire logic clk,
  // Link pins
  output logic selN,
  output logic sclk,
  output logic mosi,
  input wire logic misoOut,
  input wire logic misoOe
);
  // Released data line never shows a stale value
  logic idleBit = 1'b0;
  wire logic misoLine = misoOe ? misoOut : idleBit;
  initial
  begin
    selN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Toggling filler for the undriven line
  always @(posedge clk) idleBit <= ~idleBit;
  // Clock stands low between frames; half period four system clocks
  task automatic xfer(input logic [15:0] w, input int nBits, output logic [15:0] r);
    r = 16'h0000;
    selN <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nBits; i++)
    begin
      mosi <= w[(i > 15) ? 15 : i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      // Answer bit taken at the rising edge
      if (i < 16) r[i] = misoLine;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    selN <= 1'b1;
    mosi <= ~mosi;
    // Gap lets the write land before the next frame
    repeat (8) @(posedge clk);
  endtask
endmodule // wbm_host_model

// file: sim/wbm_regs_test.sv
// Self-checking bench for the watchdog and bus mode register bank
`timescale 1ns/1ps
module wbm_regs_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic softReset = 1'b0, restart = 1'b0, busWake = 1'b0, spiFailClr = 1'b0;
  logic wdogTimeout = 1'b0, wdogEarly = 1'b0, wdogServiceOk = 1'b0;
  logic hwWdogUpd = 1'b0, hwBusUpd = 1'b0;
  logic [7:0] hwWdogVal = 8'h00;
  logic [1:0] devMode = 2'h0, hwCan = 2'h0, hwA = 2'h0, hwB = 2'h0, hwC = 2'h0, hwD = 2'h0;
  wire selN, sclk, mosi, misoOut, misoOe, wdogStopDisable, wdogWindowSelect, wdogRunning;
  wire wdogLongWinStart, wdogResetReq, wdogResetBlocked, linFlash, linLowSlope;
  wire linTxTimeoutEn, spiFail;
  wire [9:0] wdogPeriodMs;
  wire [1:0] canModeEff, linAModeEff, linBModeEff, linCModeEff, linDModeEff;
  int n_fail = 0;
  int n_compared = 0;
  int nReq = 0;
  int nLong = 0;
  logic [15:0] r;
  logic [7:0] v;
  logic [9:0] per [8] = '{10'd10, 10'd20, 10'd50, 10'd100, 10'd200, 10'd500, 10'd1000, 10'd0};

  wbm_regs u_dut (.clk(clk), .resetn(resetn), .softReset(softReset), .restart(restart),
    .selN(selN), .sclk(sclk), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
    .devMode(devMode), .busWake(busWake), .wdogTimeout(wdogTimeout), .wdogEarly(wdogEarly),
    .wdogServiceOk(wdogServiceOk), .spiFailClr(spiFailClr), .hwWdogUpd(hwWdogUpd),
    .hwWdogVal(hwWdogVal), .hwBusUpd(hwBusUpd), .hwCanMode(hwCan), .hwLinAMode(hwA),
    .hwLinBMode(hwB), .hwLinCMode(hwC), .hwLinDMode(hwD), .wdogStopDisable(wdogStopDisable),
    .wdogWindowSelect(wdogWindowSelect), .wdogRunning(wdogRunning),
    .wdogLongWinStart(wdogLongWinStart), .wdogResetReq(wdogResetReq),
    .wdogResetBlocked(wdogResetBlocked), .wdogPeriodMs(wdogPeriodMs), .linFlash(linFlash),
    .linLowSlope(linLowSlope), .linTxTimeoutEn(linTxTimeoutEn), .canModeEff(canModeEff),
    .linAModeEff(linAModeEff), .linBModeEff(linBModeEff), .linCModeEff(linCModeEff),
    .linDModeEff(linDModeEff), .spiFail(spiFail));
  wbm_host_model u_host (.clk(clk), .selN(selN), .sclk(sclk), .mosi(mosi),
    .misoOut(misoOut), .misoOe(misoOe));

  initial forever #25 clk = ~clk;
  // Pulse counters, so short outputs are never missed
  always @(posedge clk) if (wdogResetReq === 1'b1) nReq <= nReq + 1;
  always @(posedge clk) if (wdogLongWinStart === 1'b1) nLong <= nLong + 1;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer({d, 1'b1, a}, 16, r);
  endtask
  task rd(input logic [6:0] a);
    u_host.xfer({8'h00, 1'b0, a}, 16, r);
  endtask
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task t_reset;
    rd(7'h03); check(r[15:8], 8'h14);
    rd(7'h04); check(r[15:8], 8'h20);
    rd(7'h05); check(r[15:8], 8'h00);
    // Unmapped address answers zero
    rd(7'h06); check(r[15:8], 8'h00);
    // Data line released between frames
    check(misoOe, 1'b0);
    check(wdogPeriodMs, 10'd200);
    $display("test reset done");
  endtask
  task t_period;
    for (int c = 0; c < 8; c++)
    begin
      v = 8'(c);
      v[7] = ^v[6:0];
      wr(7'h03, v);
      check(wdogPeriodMs, per[c]);
      rd(7'h03); check(r[15:8], v & 8'h7f);
    end
    $display("test period done");
  endtask
  task t_parity;
    // Odd count of ones is refused
    wr(7'h03, 8'h20);
    rd(7'h03); check(r[15:8], 8'h07);
    check(r[7:0], 8'h01);
    spiFailClr <= 1'b1; @(posedge clk); spiFailClr <= 1'b0;
    repeat (3) @(posedge clk); check(spiFail, 1'b0);
    u_host.xfer(16'h2083, 15, r); check(spiFail, 1'b1);
    spiFailClr <= 1'b1; @(posedge clk); spiFailClr <= 1'b0;
    $display("test parity done");
  endtask
  task t_wdfail;
    wr(7'h03, 8'h28);
    check(wdogWindowSelect, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wdogTimeout <= 1'b1; @(posedge clk); wdogTimeout <= 1'b0; repeat (4) @(posedge clk);
    end
    check(nReq, 3);
    check(wdogResetBlocked, 1'b1);
    wdogServiceOk <= 1'b1; @(posedge clk); wdogServiceOk <= 1'b0; repeat (2) @(posedge clk);
    wdogEarly <= 1'b1; @(posedge clk); wdogEarly <= 1'b0; repeat (4) @(posedge clk);
    check(nReq, 4);
    wr(7'h03, 8'h50);
    check(wdogStopDisable, 1'b1);
    devMode <= 2'h2; repeat (3) @(posedge clk);
    check(wdogRunning, 1'b0);
    busWake <= 1'b1; @(posedge clk); busWake <= 1'b0; repeat (3) @(posedge clk);
    check(nLong, 1);
    devMode <= 2'h0; repeat (3) @(posedge clk);
    check(wdogRunning, 1'b1);
    // Start on wake cleared: a wake in stop starts nothing
    wr(7'h03, 8'h41);
    devMode <= 2'h2;
    busWake <= 1'b1;
    @(posedge clk);
    busWake <= 1'b0;
    repeat (3) @(posedge clk);
    check(nLong, 1);
    devMode <= 2'h0;
    repeat (3) @(posedge clk);
    $display("test watchdog done");
  endtask
  task t_bus;
    wr(7'h04, 8'hff); rd(7'h04); check(r[15:8], 8'hfb);
    check({linFlash, linLowSlope, linTxTimeoutEn}, 3'h7);
    wr(7'h05, 8'hff); rd(7'h05); check(r[15:8], 8'hdb);
    wr(7'h05, 8'hd2);
    devMode <= 2'h2; repeat (3) @(posedge clk);
    check({canModeEff, linAModeEff}, 4'h5);
    check({linDModeEff, linCModeEff, linBModeEff}, 6'h1a);
    rd(7'h04); check(r[15:8], 8'hfb);
    devMode <= 2'h0; repeat (3) @(posedge clk);
    check({canModeEff, linAModeEff, linDModeEff}, 6'h3f);
    wr(7'h04, 8'h19);
    check(linLowSlope, 1'b0);
    devMode <= 2'h1; repeat (3) @(posedge clk);
    check({canModeEff, linAModeEff}, 4'h5);
    devMode <= 2'h0;
    {hwCan, hwA, hwB, hwC, hwD} <= 10'h24e;
    hwBusUpd <= 1'b1; @(posedge clk); hwBusUpd <= 1'b0;
    rd(7'h04); check(r[15:8], 8'h0a);
    rd(7'h05); check(r[15:8], 8'h98);
    $display("test bus done");
  endtask
  task t_restart;
    wr(7'h03, 8'h78); wr(7'h04, 8'hff);
    restart <= 1'b1; @(posedge clk); restart <= 1'b0; repeat (2) @(posedge clk);
    rd(7'h03); check(r[15:8], 8'h1c);
    rd(7'h04); check(r[15:8], 8'hfb);
    rd(7'h05); check(r[15:8], 8'h98);
    hwWdogVal <= 8'hff; hwWdogUpd <= 1'b1; @(posedge clk); hwWdogUpd <= 1'b0;
    rd(7'h03); check(r[15:8], 8'h5f);
    softReset <= 1'b1; @(posedge clk); softReset <= 1'b0; repeat (2) @(posedge clk);
    rd(7'h03); check(r[15:8], 8'h14);
    rd(7'h04); check(r[15:8], 8'h20);
    rd(7'h05); check(r[15:8], 8'h00);
    $display("test restart done");
  endtask

  // Hang guard, well past the expected run of about a third of a millisecond
  initial
  begin
    #2000000;
    n_fail++;
    conclude;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_period;
    t_parity;
    t_wdfail;
    t_bus;
    t_restart;
    conclude;
  end
endmodule // wbm_regs_test
